/* File: core/wwdc_counter.v */
// prescaled watchdog counter with time-out detection
`timescale 1ns/1ps
module wwdc_counter (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // control
    input  wire        tick,
    input  wire        clear,
    input  wire        run,
    input  wire [4:0]  ps,
    // status
    output reg  [22:0] count_q,
    output reg         expired_q
);
`include "wwdc_consts.vh"

    // last count value before time-out, 2^(n+5)-1
    function [22:0] wwdc_last;
        input [4:0] sel;
        reg   [4:0] eff;
        begin
            eff = (sel > `WWDC_PS_MAX) ? 5'h00 : sel;
            wwdc_last = (23'h000001 << (eff + `WWDC_PS_SHIFT)) - 23'h000001;
        end
    endfunction

    wire at_last = (count_q >= wwdc_last(ps));

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q   <= 23'h000000;
            expired_q <= 1'b0;
        end else begin
            expired_q <= 1'b0;
            if (clear || !run) begin
                count_q <= 23'h000000;
            end else if (tick) begin
                if (at_last) begin
                    count_q   <= 23'h000000;
                    expired_q <= 1'b1;
                end else begin
                    count_q <= count_q + 23'h000001;
                end
            end
        end
    end
endmodule

/* File: core/wwdc_top.v */
// windowed watchdog clear, arming and sleep control with its register file
// Overview of operation
// - counter zeroed on reset, valid clear, sleep in/out, disable, OSCILLATOR_STARTUP_TIMER, control writes
// - windowed mode needs a control 0 read to arm before a clear works
// - clear without arming is a window violation only in windowed mode
// - enabled in sleep, counting restarts from zero after the entry clear
// - leaving sleep clears the counter again
// - crystal source holds counter cleared until OSCILLATOR_STARTUP_TIMER ends; others clear once
// - time-out in sleep wakes the device instead of resetting it
// - time-out and power-down flags updated after a watchdog event
// - watchdog reset flag (active low) records a time-out reset while awake, not a window violation reset
// - off-in-sleep mode clears the counter on sleep entry
// - oscillator divider changes leave the counter alone
// - control 0 holds prescale bits 5:1, enable bit 0 reset 0, bits 7:6 zero
// - prescale n divides by 2^(n+5); codes above 10010 give minimum interval
// - default prescale code 01011, ratio 1:65536, about 2 s
// - window violation resets and clears the active-low violation flag
// - mode 01 lets the software enable bit switch the watchdog
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
module wwdc_top (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [11:0] wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire        wb_ack_o,
    // configuration settings
    input  wire [1:0]  cfg_mode_i,
    input  wire [4:0]  cfg_period_i,
    input  wire        cfg_windowed_i,
    // cpu core and clock system
    input  wire        clear_instr_i,
    input  wire        sleep_i,
    input  wire        ost_running_i,
    input  wire        sysclk_crystal_i,
    input  wire        lf_clk_i,
    // events out
    output wire        wdt_reset_o,
    output wire        wake_o,
    output wire        irq_o
);
`include "wwdc_consts.vh"

    // captured configuration
    reg  [1:0]  mode_q;
    reg         windowed_q;
    reg         cfg_done_q;

    // registers
    reg  [4:0]  ps_q;
    reg         sen_q;
    reg  [7:0]  ctrl1_q;
    reg         to_n_q;
    reg         pd_n_q;
    reg         watchdog_reset_flag_n_n_q;
    reg         wv_n_q;
    reg         armed_q;
    reg  [2:0]  istat_q;
    reg  [2:0]  imask_q;

    // bus
    reg         ack_q;
    reg  [31:0] dat_q;

    // event state
    reg         sleep_q;
    reg         hold_q;
    reg         reset_q;
    reg         wake_q;

    // low-frequency clock synchroniser
    reg         lf_s1_q;
    reg         lf_s2_q;
    reg         lf_s3_q;

    wire        expired;

    // strap capture after reset release; configuration is fixed after that
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q     <= `WWDC_MODE_OFF;
            windowed_q <= 1'b0;
            cfg_done_q <= 1'b0;
        end else if (!cfg_done_q) begin
            mode_q     <= cfg_mode_i;
            windowed_q <= cfg_windowed_i;
            cfg_done_q <= 1'b1;
        end
    end

    // oscillator edge only from the second stage onward
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lf_s1_q <= 1'b0;
            lf_s2_q <= 1'b0;
            lf_s3_q <= 1'b0;
        end else begin
            lf_s1_q <= lf_clk_i;
            lf_s2_q <= lf_s1_q;
            lf_s3_q <= lf_s2_q;
        end
    end

    wire lf_tick = lf_s2_q & ~lf_s3_q;

    // bus decode
    wire bus_req  = wb_cyc_i & wb_stb_i;
    wire bus_done = bus_req & ack_q;
    wire wr_done  = bus_done & wb_we_i & wb_sel_i[0];
    wire rd_done  = bus_done & ~wb_we_i;
    wire hit_c0   = (wb_adr_i == `WWDC_ADR_CTRL0);
    wire hit_c1   = (wb_adr_i == `WWDC_ADR_CTRL1);
    wire hit_fl   = (wb_adr_i == `WWDC_ADR_FLAGS);
    wire hit_is   = (wb_adr_i == `WWDC_ADR_ISTAT);
    wire hit_im   = (wb_adr_i == `WWDC_ADR_IMASK);
    wire wr_ctrl  = wr_done & (hit_c0 | hit_c1);
    wire rd_c0    = rd_done & hit_c0;

    // watchdog active per mode and sleep state
    reg active;
    always @* begin
        case (mode_q)
            `WWDC_MODE_ON:      active = 1'b1;
            `WWDC_MODE_NOSLEEP: active = ~sleep_i;
            `WWDC_MODE_SW:      active = sen_q;
            `WWDC_MODE_OFF:     active = 1'b0;
            default:            active = 1'b0;
        endcase
    end

    // sleep edges
    wire sleep_enter = sleep_i & ~sleep_q;
    wire sleep_exit  = ~sleep_i & sleep_q;

    // clear instruction split by arming
    wire need_arm    = windowed_q;
    wire clr_valid   = clear_instr_i & (armed_q | ~need_arm);
    wire clr_violate = clear_instr_i & need_arm & ~armed_q;

    // post-wake hold for crystal sources until start-up timer ends
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_q <= 1'b0;
        end else if (sleep_exit & sysclk_crystal_i) begin
            hold_q <= 1'b1;
        end else if (!ost_running_i) begin
            hold_q <= 1'b0;
        end
    end

    // divider changes are deliberately absent from the clear sources
    wire counter_clear = clr_valid
                       | sleep_enter
                       | sleep_exit
                       | ~active
                       | ost_running_i
                       | hold_q
                       | wr_ctrl;

    wwdc_counter u_counter (
        .clk       (clk),
        .rst_n     (rst_n),
        .tick      (lf_tick),
        .clear     (counter_clear),
        .run       (active),
        .ps        (ps_q),
        .count_q   (),
        .expired_q (expired)
    );

    wire timeout_sleep = expired & sleep_q;
    wire timeout_awake = expired & ~sleep_q;

    // sleep tracking and event pulses
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_q <= 1'b0;
            reset_q <= 1'b0;
            wake_q  <= 1'b0;
        end else begin
            sleep_q <= sleep_i;
            reset_q <= timeout_awake | clr_violate;
            wake_q  <= timeout_sleep;
        end
    end

    // arming: a read of control 0 arms, any clear attempt disarms
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
        end else if (clear_instr_i) begin
            armed_q <= 1'b0;
        end else if (rd_c0) begin
            armed_q <= 1'b1;
        end
    end

    // control registers; prescale reset follows the period setting
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ps_q    <= `WWDC_PS_RST;
            sen_q   <= `WWDC_SEN_RST;
            ctrl1_q <= `WWDC_CTRL1_RST;
        end else if (!cfg_done_q) begin
            ps_q <= (cfg_period_i == `WWDC_PS_CFG_SW) ? `WWDC_PS_RST : cfg_period_i;
        end else if (wr_done) begin
            if (hit_c0) begin
                ps_q  <= wb_dat_i[`WWDC_PS_MSB:`WWDC_PS_LSB];
                sen_q <= wb_dat_i[`WWDC_SEN_BIT];
            end
            if (hit_c1) begin
                ctrl1_q <= wb_dat_i[7:0];
            end
        end
    end

    // status flags; hardware events win over a software write
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            to_n_q   <= 1'b1;
            pd_n_q   <= 1'b1;
            watchdog_reset_flag_n_n_q <= 1'b1;
            wv_n_q   <= 1'b1;
        end else begin
            if (expired) begin
                to_n_q <= 1'b0;
                pd_n_q <= ~sleep_q;
            end else if (sleep_enter) begin
                to_n_q <= 1'b1;
                pd_n_q <= 1'b0;
            end else if (clr_valid) begin
                to_n_q <= 1'b1;
                pd_n_q <= 1'b1;
            end else if (wr_done & hit_fl) begin
                to_n_q <= to_n_q | wb_dat_i[`WWDC_FL_TO_N];
                pd_n_q <= pd_n_q | wb_dat_i[`WWDC_FL_PD_N];
            end
            if (timeout_awake) begin
                watchdog_reset_flag_n_n_q <= 1'b0;
            end else if (wr_done & hit_fl & wb_dat_i[`WWDC_FL_WATCHDOG_RESET_FLAG_N_N]) begin
                watchdog_reset_flag_n_n_q <= 1'b1;
            end
            if (clr_violate) begin
                wv_n_q <= 1'b0;
            end else if (wr_done & hit_fl & wb_dat_i[`WWDC_FL_WV_N]) begin
                wv_n_q <= 1'b1;
            end
        end
    end

    // interrupt status, write one to clear, a new event wins
    wire [2:0] irq_set;
    assign irq_set[`WWDC_IRQ_TIMEOUT] = expired;
    assign irq_set[`WWDC_IRQ_VIOL]    = clr_violate;
    assign irq_set[`WWDC_IRQ_WAKE]    = timeout_sleep;

    wire [2:0] irq_clr = (wr_done & hit_is) ? wb_dat_i[2:0] : 3'h0;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            istat_q <= 3'h0;
            imask_q <= 3'h0;
        end else begin
            istat_q <= (istat_q & ~irq_clr) | irq_set;
            if (wr_done & hit_im) begin
                imask_q <= wb_dat_i[2:0];
            end
        end
    end

    // read mux
    reg [31:0] rd_data;
    always @* begin
        rd_data = 32'h00000000;
        if (hit_c0) begin
            rd_data[`WWDC_PS_MSB:`WWDC_PS_LSB] = ps_q;
            rd_data[`WWDC_SEN_BIT]             = sen_q;
        end else if (hit_c1) begin
            rd_data[7:0] = ctrl1_q;
        end else if (hit_fl) begin
            rd_data[`WWDC_FL_TO_N]   = to_n_q;
            rd_data[`WWDC_FL_PD_N]   = pd_n_q;
            rd_data[`WWDC_FL_WATCHDOG_RESET_FLAG_N_N] = watchdog_reset_flag_n_n_q;
            rd_data[`WWDC_FL_WV_N]   = wv_n_q;
            rd_data[`WWDC_FL_ARMED]  = armed_q;
            rd_data[`WWDC_FL_ACTIVE] = active;
        end else if (hit_is) begin
            rd_data[2:0] = istat_q;
        end else if (hit_im) begin
            rd_data[2:0] = imask_q;
        end
    end

    // one wait state; data captured on the request edge stays put through ack
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= bus_req & ~ack_q;
            if (bus_req & ~ack_q & ~wb_we_i) begin
                dat_q <= rd_data;
            end
        end
    end

    assign wb_ack_o    = ack_q;
    assign wb_dat_o    = dat_q;
    assign wdt_reset_o = reset_q;
    assign wake_o      = wake_q;
    assign irq_o       = |(istat_q & imask_q);

endmodule

/* File: shared/wwdc_consts.vh */
// constants for the windowed watchdog clear control block
`ifndef WWDC_CONSTS_VH
`define WWDC_CONSTS_VH

// register byte addresses
`define WWDC_ADR_CTRL0      12'h18c
`define WWDC_ADR_CTRL1      12'h190
`define WWDC_ADR_FLAGS      12'h194
`define WWDC_ADR_ISTAT      12'h198
`define WWDC_ADR_IMASK      12'h19c

// control 0 fields
`define WWDC_SEN_BIT        0
`define WWDC_PS_LSB         1
`define WWDC_PS_MSB         5

// flags register fields
`define WWDC_FL_TO_N        0
`define WWDC_FL_PD_N        1
`define WWDC_FL_WATCHDOG_RESET_FLAG_N_N      2
`define WWDC_FL_WV_N        3
`define WWDC_FL_ARMED       4
`define WWDC_FL_ACTIVE      5

// interrupt status fields
`define WWDC_IRQ_TIMEOUT    0
`define WWDC_IRQ_VIOL       1
`define WWDC_IRQ_WAKE       2
`define WWDC_IRQ_W          3

// reset values
`define WWDC_PS_RST         5'h0b
`define WWDC_PS_CFG_SW      5'h1f
`define WWDC_SEN_RST        1'b0
`define WWDC_CTRL1_RST      8'h00
`define WWDC_FLAGS_RST      4'hf

// prescaler timing
`define WWDC_PS_MAX         5'h12
`define WWDC_PS_SHIFT       5
`define WWDC_CNT_W          23

// watchdog mode configuration codes
`define WWDC_MODE_OFF       2'b00
`define WWDC_MODE_SW        2'b01
`define WWDC_MODE_NOSLEEP   2'b10
`define WWDC_MODE_ON        2'b11

`endif

/* File: verification/tb_top.sv */
// self-checking bench for the watchdog clear control block
`timescale 1ns/1ps
`include "wwdc_consts.vh"
module tb_top;
    logic clk = 1'b0;
    logic rst_n, win, cyc, stb, we, ack, clr, slp, oscillator_startup_timer, xtal, lf, wrst, wake, irq;
    logic [1:0] mode;
    logic [4:0] per;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [7:0] q, v;
    integer error_cnt, tests_run, rst_cnt, wake_cnt, seed, i;
    always #4 clk = ~clk;
    // event counts restart with every reset of the block
    always @(posedge clk) begin
        if (!rst_n) begin
            rst_cnt  <= 0;
            wake_cnt <= 0;
        end else begin
            if (wrst === 1'b1) rst_cnt <= rst_cnt + 1;
            if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
        end
    end
    wwdc_top i_wwdc_top (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cfg_mode_i(mode),
        .cfg_period_i(per), .cfg_windowed_i(win), .clear_instr_i(clr), .sleep_i(slp), .ost_running_i(oscillator_startup_timer),
        .sysclk_crystal_i(xtal), .lf_clk_i(lf), .wdt_reset_o(wrst), .wake_o(wake), .irq_o(irq));
    wwdc_cpu_model i_wwdc_cpu_model (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
        .wdat(wdat), .ack(ack), .rdat(rdat), .clr(clr), .slp(slp), .oscillator_startup_timer(oscillator_startup_timer), .xtal(xtal), .lf(lf));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic start(input logic [1:0] m, input logic [4:0] p, input logic w);
        rst_n <= 1'b0;
        {mode, per, win} <= {m, p, w};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a);
        i_wwdc_cpu_model.bus(1'b0, a, 8'h00, q);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        i_wwdc_cpu_model.bus(1'b1, a, d, q);
    endtask
    task automatic idle(input integer n);
        repeat (n) @(posedge clk);
    endtask
    // all-ones strap means the fixed default code
    function automatic logic [7:0] exp_ctrl0(input logic [4:0] p);
        return (p == 5'h1f) ? 8'h16 : {2'b00, p, 1'b0};
    endfunction
    task automatic report_and_stop();
        $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #500000;
        error_cnt = error_cnt + 1;
        report_and_stop();
    end
    initial begin
        {rst_n, win, mode, per} = 9'h1f;
        {error_cnt, tests_run} = '0;
        i_wwdc_cpu_model.reset_lines();
        seed = 32'hc01f;
        for (i = 0; i < 4; i++) begin
            v = (i == 0) ? 8'h1f : 8'($random(seed));
            start(2'b11, v[4:0], 1'b1);
            rd(`WWDC_ADR_FLAGS);
            chk("flags at reset", q[4:0], 5'h0f);
            rd(`WWDC_ADR_CTRL0);
            chk("control 0 reset", q, exp_ctrl0(v[4:0]));
            v = 8'($random(seed));
            wr(`WWDC_ADR_CTRL0, v);
            rd(`WWDC_ADR_CTRL0);
            chk("control 0 readback", q, v & 8'h3f);
        end
        wr(12'h1a0, 8'hff);
        rd(12'h1a0);
        chk("unmapped read", q, 8'h00);
        $display("register test done");
        start(2'b11, 5'h1f, 1'b1);
        i_wwdc_cpu_model.clear();
        idle(3);
        chk("unarmed clear", rst_cnt, 1);
        rd(`WWDC_ADR_FLAGS);
        chk("violation flag", q[5:0], 6'h27);
        rd(`WWDC_ADR_ISTAT);
        chk("violation status", q[2:0], 3'h2);
        wr(`WWDC_ADR_FLAGS, 8'h08);
        rd(`WWDC_ADR_FLAGS);
        chk("violation flag set back", q[3:0], 4'hf);
        i_wwdc_cpu_model.arm_clear();
        idle(3);
        chk("armed clear", rst_cnt, 1);
        start(2'b11, 5'h1f, 1'b0);
        i_wwdc_cpu_model.clear();
        idle(3);
        chk("plain clear", rst_cnt, 0);
        $display("arming test done");
        start(2'b11, 5'h00, 1'b1);
        for (i = 0; i < 6; i++) begin
            if (i % 2) wr(`WWDC_ADR_CTRL1, 8'($random(seed)));
            else i_wwdc_cpu_model.arm_clear();
            idle(100);
        end
        chk("clears hold off", rst_cnt, 0);
        idle(400);
        chk("awake timeout", rst_cnt > 0, 1);
        rd(`WWDC_ADR_FLAGS);
        chk("awake timeout flags", q[3:0], 4'ha);
        $display("timeout test done");
        start(2'b11, 5'h00, 1'b1);
        i_wwdc_cpu_model.set_lines(1'b1, 1'b0, 1'b0);
        idle(400);
        chk("sleep wake", wake_cnt > 0, 1);
        chk("no reset asleep", rst_cnt, 0);
        i_wwdc_cpu_model.set_lines(1'b0, 1'b0, 1'b0);
        rd(`WWDC_ADR_FLAGS);
        chk("sleep timeout flags", q[3:0], 4'hc);
        chk("irq masked", irq, 1'b0);
        wr(`WWDC_ADR_IMASK, 8'h04);
        @(negedge clk);
        chk("irq raised", irq, 1'b1);
        wr(`WWDC_ADR_ISTAT, 8'h04);
        @(negedge clk);
        chk("irq cleared", irq, 1'b0);
        $display("sleep test done");
        start(2'b10, 5'h00, 1'b1);
        i_wwdc_cpu_model.set_lines(1'b1, 1'b0, 1'b0);
        idle(400);
        chk("mode 10 asleep", wake_cnt, 0);
        i_wwdc_cpu_model.set_lines(1'b0, 1'b0, 1'b0);
        start(2'b01, 5'h00, 1'b1);
        idle(400);
        chk("mode 01 disabled", rst_cnt, 0);
        // reserved prescale code must fall back to the shortest interval
        wr(`WWDC_ADR_CTRL0, 8'h3f);
        idle(400);
        chk("mode 01 enabled", rst_cnt > 0, 1);
        start(2'b11, 5'h00, 1'b1);
        i_wwdc_cpu_model.set_lines(1'b0, 1'b1, 1'b1);
        idle(400);
        chk("start-up timer hold", rst_cnt, 0);
        i_wwdc_cpu_model.set_lines(1'b1, 1'b0, 1'b0);
        idle(200);
        i_wwdc_cpu_model.set_lines(1'b0, 1'b0, 1'b0);
        idle(200);
        chk("sleep exit clear", rst_cnt + wake_cnt, 0);
        $display("mode test done");
        report_and_stop();
    end
endmodule

/* File: verification/wwdc_cpu_model.sv */
// cpu core model: bus master, clear instructions, sleep and clock status
`timescale 1ns/1ps
`include "wwdc_consts.vh"
module wwdc_cpu_model (
    // clock
    input  logic        clk,
    // wishbone master
    output logic        cyc,
    output logic        stb,
    output logic        we,
    output logic [11:0] adr,
    output logic [3:0]  sel,
    output logic [31:0] wdat,
    input  logic        ack,
    input  logic [31:0] rdat,
    // core and clock system
    output logic        clr,
    output logic        slp,
    output logic        oscillator_startup_timer,
    output logic        xtal,
    output logic        lf
);
    // bench calls this at time zero; keeps one driving process per line
    task automatic reset_lines();
        {cyc, stb, we, sel, clr, slp, oscillator_startup_timer, xtal} = '0;
        adr = 12'h000;
        wdat = 32'h0;
    endtask
    // period not a multiple of clk, so phase drifts
    initial begin
        lf = 1'b0;
        forever #37 lf = ~lf;
    end
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        {cyc, stb, we, adr, sel} <= {2'b11, w, a, 4'hf};
        wdat <= {24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat[7:0];
        {cyc, stb, sel} <= 6'h0;
        // released lines carry junk, never the old value
        adr <= ~a;
        wdat <= ~wdat;
    endtask
    task automatic clear();
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask
    task automatic arm_clear();
        logic [7:0] q;
        bus(1'b0, `WWDC_ADR_CTRL0, 8'h00, q);
        clear();
    endtask
    task automatic set_lines(input logic s, input logic o, input logic x);
        @(posedge clk);
        {slp, oscillator_startup_timer, xtal} <= {s, o, x};
    endtask
endmodule

/* File: verification/wwdc_props.sv */
// port assertions for the watchdog clear control block
`timescale 1ns/1ps
`include "wwdc_consts.vh"
module wwdc_props (
    // clock and reset
    input logic        clk,
    input logic        rst_n,
    // register bus
    input logic        wb_cyc_i,
    input logic        wb_stb_i,
    input logic        wb_we_i,
    input logic [11:0] wb_adr_i,
    input logic [31:0] wb_dat_o,
    input logic        wb_ack_o,
    // core side and events
    input logic        cfg_windowed_i,
    input logic        clear_instr_i,
    input logic        sleep_i,
    input logic        ost_running_i,
    input logic        wdt_reset_o,
    input logic        wake_o
);
    logic armed_q;
    logic armed_d;
    logic rd_ack;
    logic mapped;
    assign rd_ack = wb_cyc_i && wb_stb_i && wb_ack_o && !wb_we_i;
    assign mapped = wb_adr_i inside {`WWDC_ADR_CTRL0, `WWDC_ADR_CTRL1, `WWDC_ADR_FLAGS, `WWDC_ADR_ISTAT,
                                     `WWDC_ADR_IMASK};
    // a clear attempt always disarms, even beside an arming read
    assign armed_d = clear_instr_i ? 1'b0 : (rd_ack && wb_adr_i == `WWDC_ADR_CTRL0) ? 1'b1 : armed_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) armed_q <= 1'b0;
        else armed_q <= armed_d;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence quiet8_s;
        (!wdt_reset_o && !wake_o)[*8];
    endsequence
    // two cycles skip a time-out already in the pipeline
    sequence settle_s;
        ##2 quiet8_s;
    endsequence
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    unmapped_zero_a: assert property (rd_ack && !mapped |-> wb_dat_o == 32'h0) else $error("unmapped read");
    ctrl0_upper_a: assert property (rd_ack && wb_adr_i == `WWDC_ADR_CTRL0 |-> wb_dat_o[31:6] == 26'h0)
        else $error("control 0 upper bits set");
    unarmed_viol_a: assert property (clear_instr_i && cfg_windowed_i && !armed_q |=> wdt_reset_o)
        else $error("unarmed clear not refused");
    armed_clear_a: assert property (clear_instr_i && (!cfg_windowed_i || armed_q) |=> !wdt_reset_o ##1 settle_s)
        else $error("valid clear did not restart count");
    wake_asleep_a: assert property (wake_o |-> $past(sleep_i, 2) && !wdt_reset_o)
        else $error("wake outside sleep");
    sleep_entry_a: assert property ($rose(sleep_i) |-> settle_s) else $error("no clear on sleep entry");
    ost_hold_a: assert property (ost_running_i[*3] ##0 !clear_instr_i |=> !wake_o && !wdt_reset_o)
        else $error("count ran under start-up timer");
endmodule
bind wwdc_top wwdc_props i_wwdc_props (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cfg_windowed_i(cfg_windowed_i), .clear_instr_i(clear_instr_i), .sleep_i(sleep_i),
    .ost_running_i(ost_running_i), .wdt_reset_o(wdt_reset_o), .wake_o(wake_o));
